// ===== rtl/serial_channel_pkg.sv
// Register map, field layout and encodings of the asynchronous serial channel.
package serial_channel_pkg;
	localparam logic [4:0] CTRL_OFS = 5'h00;
	localparam logic [4:0] STAT_OFS = 5'h04;
	localparam logic [4:0] DATA_OFS = 5'h08;
	localparam logic [4:0] DIV_OFS = 5'h0c;
	localparam logic [4:0] CFG_OFS = 5'h10;
	localparam int CTRL_EXT_LSB = 0;
	localparam int CTRL_MODE_LSB = 3;
	localparam int ST_RI_LSB = 0;
	localparam int ST_TI_LSB = 2;
	localparam int ST_NINTH_LSB = 4;
	localparam int ST_OVW_LSB = 6;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic TI_RST = 1'b1;
	localparam logic [1:0] CMD_CLEAR = 2'h2;
	localparam logic [1:0] CMD_SET = 2'h3;
	localparam logic [3:0] LAST_SAMPLE = 4'hf;
	localparam logic [3:0] TX_LAST_BIT = 4'ha;
	localparam logic [3:0] RX_NINTH_IDX = 4'h8;
	localparam logic [3:0] RX_STOP_IDX = 4'h9;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		MODE_OFF = 2'b00,
		MODE_ASYNC = 2'b01,
		MODE_PACKET = 2'b10,
		MODE_LINK = 2'b11
	} mode_t;

	typedef enum logic [1:0]
	{
		NINTH_STOP = 2'b00,
		NINTH_EVEN = 2'b01,
		NINTH_ODD = 2'b10,
		NINTH_USER = 2'b11
	} ninth_t;

	typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
	typedef enum logic {RX_HUNT = 1'b0, RX_BITS = 1'b1} rx_state_t;

	typedef struct packed
	{
		logic async_en;
		logic packet_rx;
		logic packet_tx;
		logic packet_repeat;
		logic link_en;
		logic link_master;
		logic link_wide;
		logic link_output;
	} cfg_t;
endpackage : serial_channel_pkg

// ===== rtl/serial_channel.sv
// Asynchronous serial channel with mode decoding and an Avalon-MM slave.
// What this block does
// R1: Mode 01 with low extension bits 00 sends no parity, two stop bits.
// R2: Low extension 01 even, 10 odd, 11 fixed top-bit ninth, one stop.
// R3: Mode 10 low bit picks packet receive or send; mid bit repeats a send.
// R4: Mode 11 top bit master, mid bit 16-bit words, low bit output.
// R5: In mode 01 transmit and receive run at the same time.
// R6: Async data goes out on the frame valid line, in on data line.
// R7: A sent frame is start, eight data bits LSB first, ninth, stop.
// R8: Ninth sent bit is parity, user bit or first stop per format.
// R9: Moving the hold byte into the shifter sets the hold-empty flag.
// R10: Writing the data buffer or the flag field clears hold-empty.
// R11: A second write before the move replaces the unsent byte.
// R12: The receiver samples its input at sixteen times the bit rate.
// R13: Start is seen when samples 1, 7, 8 and 9 of sixteen are low.
// R14: Each later bit is a majority of samples 7, 8, 9 of its period.
// R15: Received data bits shift in, first bit ending as the LSB.
// R16: The tenth received bit is checked per format and always stored.
// R17: A good frame moves to the hold register after the eleventh bit.
// R18: Bad parity or missing stop discards the frame untouched.
// R19: Filling the receive hold register sets the hold-full flag.
// R20: Reading the data buffer or writing the flag field clears it.
// R21: A new byte replaces an unread one in the receive hold register.
// R22: Overwrite sets the overrun flag; writes 10 clear, 11 set it.
// R23: Hold-full reads 01 when full, 00 when empty; 0X writes nothing.
// R24: Bit rate is clock over sixteen times divider; zero means 65536.
// R25: The transmit line idles high; start is low and stops are high.
// R26: The peer uses the same rate, parity and stops, LSB first.
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
module serial_channel
	import serial_channel_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic frame_valid_line_in,
	output logic frame_valid_line_out,
	output logic frame_valid_line_oe,
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_oe,
	output cfg_t channel_cfg
);

	generate
		if (DIV_W < 2 || DIV_W > 16)
		begin : g_bad_width
			$error("DIV_W must lie between 2 and 16.");
		end
	endgenerate

	function automatic logic ninth_bit(input logic [1:0] fmt,
		input logic [7:0] data, input logic user);
		logic bit_v;
		bit_v = 1'b1;
		case (fmt)
			NINTH_STOP: bit_v = 1'b1;
			NINTH_EVEN: bit_v = ^data;
			NINTH_ODD: bit_v = ~^data;
			NINTH_USER: bit_v = user;
			default: bit_v = 1'b1;
		endcase
		return bit_v;
	endfunction : ninth_bit

	function automatic logic [1:0] pair_next(input logic [1:0] cmd,
		input logic cur);
		logic [1:0] res;
		res = {1'b0, cur};
		if (cmd == CMD_CLEAR)
		begin
			res = 2'b10;
		end
		else if (cmd == CMD_SET)
		begin
			res = 2'b11;
		end
		return res;
	endfunction : pair_next

	logic ack_q;
	logic [31:0] readdata_q;
	logic [4:0] ctrl_q;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_cnt_q;
	logic ti_q;
	logic ri_q;
	logic ovw_q;
	logic rb8_q;
	logic [7:0] tx_hold_q;
	logic [7:0] rx_hold_q;
	tx_state_t tx_state_q;
	logic [10:0] tx_frame_q;
	logic [3:0] tx_sub_q;
	logic [3:0] tx_bit_q;
	rx_state_t rx_state_q;
	logic [15:0] hist_q;
	logic [3:0] rx_sub_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_shift_q;

	wire req = read | write;
	wire wr_fire = write & ack_q;
	wire rd_fire = read & ack_q;
	wire sel_ctrl = address == CTRL_OFS;
	wire sel_stat = address == STAT_OFS;
	wire sel_data = address == DATA_OFS;
	wire sel_div = address == DIV_OFS;
	wire sel_cfg = address == CFG_OFS;
	wire wr_ctrl = wr_fire & sel_ctrl;
	wire wr_stat = wr_fire & sel_stat;
	wire wr_data = wr_fire & sel_data;
	wire wr_div = wr_fire & sel_div;
	wire rd_data = rd_fire & sel_data;

	wire [1:0] mode = ctrl_q[CTRL_MODE_LSB +: 2];
	wire [2:0] ext = ctrl_q[CTRL_EXT_LSB +: 3];
	wire [1:0] fmt = ext[1:0];
	wire async_en = mode == MODE_ASYNC;

	assign channel_cfg.async_en = async_en; // [R5]
	assign channel_cfg.packet_rx = mode == MODE_PACKET && !ext[0]; // [R3]
	assign channel_cfg.packet_tx = mode == MODE_PACKET && ext[0]; // [R3]
	assign channel_cfg.packet_repeat = mode == MODE_PACKET && ext[0]
		&& ext[1]; // [R3]
	assign channel_cfg.link_en = mode == MODE_LINK; // [R4]
	assign channel_cfg.link_master = mode == MODE_LINK && ext[2]; // [R4]
	assign channel_cfg.link_wide = mode == MODE_LINK && ext[1]; // [R4]
	assign channel_cfg.link_output = mode == MODE_LINK && ext[0]; // [R4]

	// Status reads hold two-bit fields whose upper bit reads zero.
	wire [7:0] stat_rd = {1'b0, ovw_q, 1'b0, rb8_q, 1'b0, ti_q, 1'b0,
		ri_q}; // [R23]
	wire [31:0] rd_mux = sel_ctrl ? {27'h0, ctrl_q} :
		sel_stat ? {24'h0, stat_rd} :
		sel_data ? {24'h0, rx_hold_q} :
		sel_div ? {{(32-DIV_W){1'b0}}, div_q} :
		sel_cfg ? {24'h0, channel_cfg} : UNMAPPED_READ;

	// Every access waits one cycle, then completes.
	assign waitrequest = req & ~ack_q;
	assign readdata = readdata_q;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			readdata_q <= (read & ~ack_q) ? rd_mux : readdata_q;
		end
	end

	wire [DIV_W-1:0] div_last = div_q - 1'b1;
	// A smaller divider written mid-count takes effect without a long wrap.
	wire tick = div_cnt_q >= div_last; // [R24] [R12]

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RST;
			div_q <= DIV_RST[DIV_W-1:0];
			div_cnt_q <= '0;
			tx_hold_q <= 8'h00;
		end
		else
		begin
			ctrl_q <= wr_ctrl ? writedata[4:0] : ctrl_q;
			div_q <= wr_div ? writedata[DIV_W-1:0] : div_q;
			div_cnt_q <= tick ? '0 : div_cnt_q + 1'b1;
			tx_hold_q <= wr_data ? writedata[7:0] : tx_hold_q; // [R11]
		end
	end

	// Transmitter: a hold byte loads on a sample tick when the line is idle.
	// A data write in the same cycle defers the load so no byte is lost.
	wire tx_load = async_en & tx_state_q == TX_IDLE & ~ti_q & ~wr_data
		& tick; // [R9]
	wire tx_bit_end = tick & tx_sub_q == LAST_SAMPLE;
	wire [10:0] tx_frame_new = {1'b1, ninth_bit(fmt, tx_hold_q, ext[2]),
		tx_hold_q, 1'b0}; // [R7] [R8] [R1] [R2]

	always_ff @(posedge ref_clk)
	begin
		if (rst || !async_en)
		begin
			tx_state_q <= TX_IDLE;
			tx_frame_q <= 11'h7ff;
			tx_sub_q <= 4'h0;
			tx_bit_q <= 4'h0;
		end
		else if (tx_load)
		begin
			tx_state_q <= TX_SEND;
			tx_frame_q <= tx_frame_new; // [R7]
			tx_sub_q <= 4'h0;
			tx_bit_q <= 4'h0;
		end
		else if (tx_state_q == TX_SEND && tick)
		begin
			tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_bit_end)
			begin
				tx_frame_q <= {1'b1, tx_frame_q[10:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
				tx_state_q <= tx_bit_q == TX_LAST_BIT ? TX_IDLE : TX_SEND;
			end
		end
	end

	wire txd = tx_state_q == TX_SEND ? tx_frame_q[0] : 1'b1; // [R25]
	assign frame_valid_line_out = async_en ? txd : 1'b1; // [R6]
	assign frame_valid_line_oe = async_en; // [R6]
	assign serial_data_line_out = 1'b1;
	assign serial_data_line_oe = 1'b0; // [R6]

	// Receiver: sixteen-sample history of the data line.
	wire [15:0] hist_d = tick ? {hist_q[14:0], serial_data_line_in} : hist_q;
	wire rx_start = async_en & rx_state_q == RX_HUNT & tick & ~hist_d[15]
		& ~hist_d[9] & ~hist_d[8] & ~hist_d[7]; // [R13]
	wire vote = (hist_d[9] & hist_d[8]) | (hist_d[9] & hist_d[7])
		| (hist_d[8] & hist_d[7]); // [R14]
	wire rx_decide = rx_state_q == RX_BITS & tick
		& rx_sub_q == LAST_SAMPLE; // [R14]
	wire parity_ok = fmt == NINTH_STOP ? rb8_q :
		fmt == NINTH_EVEN ? ~(^{rx_shift_q, rb8_q}) :
		fmt == NINTH_ODD ? ^{rx_shift_q, rb8_q} : 1'b1; // [R16]
	wire frame_ok = parity_ok & vote; // [R18]
	wire rx_done = rx_decide & rx_bit_q == RX_STOP_IDX & frame_ok; // [R17]

	always_ff @(posedge ref_clk)
	begin
		if (rst || !async_en)
		begin
			rx_state_q <= RX_HUNT;
			hist_q <= 16'hffff;
			rx_sub_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_shift_q <= 8'h00;
		end
		else
		begin
			hist_q <= hist_d; // [R12]
			if (rx_start)
			begin
				rx_state_q <= RX_BITS;
				rx_sub_q <= 4'h0;
				rx_bit_q <= 4'h0;
			end
			else if (rx_state_q == RX_BITS && tick)
			begin
				rx_sub_q <= rx_sub_q + 4'h1;
				if (rx_decide)
				begin
					rx_bit_q <= rx_bit_q + 4'h1;
					if (rx_bit_q < RX_NINTH_IDX)
					begin
						rx_shift_q <= {vote, rx_shift_q[7:1]}; // [R15]
					end
					if (rx_bit_q == RX_STOP_IDX)
					begin
						rx_state_q <= RX_HUNT;
					end
				end
			end
		end
	end

	// Flags: hardware set wins over any clear in the same cycle.
	wire [1:0] ti_sw = pair_next(writedata[ST_TI_LSB +: 2], ti_q);
	wire [1:0] ri_sw = pair_next(writedata[ST_RI_LSB +: 2], ri_q);
	wire [1:0] ovw_sw = pair_next(writedata[ST_OVW_LSB +: 2], ovw_q);
	wire rb8_take = rx_decide & rx_bit_q == RX_NINTH_IDX;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ti_q <= TI_RST;
			ri_q <= 1'b0;
			ovw_q <= 1'b0;
			rb8_q <= 1'b0;
			rx_hold_q <= 8'h00;
		end
		else
		begin
			if (tx_load)
			begin
				ti_q <= 1'b1; // [R9]
			end
			else if (wr_data)
			begin
				ti_q <= 1'b0; // [R10]
			end
			else if (wr_stat)
			begin
				ti_q <= ti_sw[0]; // [R10]
			end
			if (rx_done)
			begin
				ri_q <= 1'b1; // [R19]
			end
			else if (rd_data)
			begin
				ri_q <= 1'b0; // [R20]
			end
			else if (wr_stat)
			begin
				ri_q <= ri_sw[0]; // [R20] [R23]
			end
			if (rx_done && ri_q)
			begin
				ovw_q <= 1'b1; // [R22]
			end
			else if (wr_stat)
			begin
				ovw_q <= ovw_sw[0]; // [R22]
			end
			rb8_q <= rb8_take ? vote : rb8_q; // [R16]
			rx_hold_q <= rx_done ? rx_shift_q : rx_hold_q; // [R17] [R21]
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	wait_one_a: assert property (waitrequest |=> !waitrequest)
		else $error("Access not answered after one wait cycle.");

	start_low_a: assert property ( // [R25]
		tx_load |=> !frame_valid_line_out [*2])
		else $error("Start bit not driven low.");

	ti_load_a: assert property (tx_load |=> ti_q) // [R9]
		else $error("Hold-empty flag not set on load.");

	ti_write_a: assert property (wr_data |=> !ti_q) // [R10]
		else $error("Hold-empty flag not cleared by data write.");

	frame_data_a: assert property ( // [R7]
		tx_load |=> tx_frame_q[8:1] == $past(tx_hold_q)
			&& !tx_frame_q[0] && tx_frame_q[10])
		else $error("Transmit frame layout wrong.");

	even_par_a: assert property ( // [R8]
		tx_load && fmt == NINTH_EVEN |=> !(^tx_frame_q[9:1]))
		else $error("Even parity wrong on transmit.");

	rx_fill_a: assert property ( // [R19]
		rx_done |=> ri_q && rx_hold_q == $past(rx_shift_q))
		else $error("Received byte not placed in hold register.");

	bad_keep_a: assert property ( // [R18]
		rx_decide && rx_bit_q == RX_STOP_IDX && !frame_ok
			&& !rd_data && !wr_stat
			|=> $stable(rx_hold_q) && ri_q == $past(ri_q))
		else $error("Bad frame changed the hold register.");

	overrun_a: assert property (rx_done && ri_q |=> ovw_q) // [R22]
		else $error("Overrun not flagged.");

	ri_read_a: assert property (rd_data && !rx_done |=> !ri_q) // [R20]
		else $error("Hold-full flag not cleared by read.");

	start_seen_a: assert property ( // [R13]
		rx_start |=> rx_state_q == RX_BITS && rx_sub_q == 4'h0)
		else $error("Start detection did not begin a frame.");

	line_role_a: assert property ( // [R6]
		async_en |-> frame_valid_line_oe && !serial_data_line_oe)
		else $error("Line directions wrong in async mode.");

endmodule : serial_channel

// ===== bench/serial_peer.sv
// Remote asynchronous peer that sends frames and captures received ones.
`timescale 1ns/1ns
module serial_peer
(
	input wire logic clk,
	input wire logic [7:0] bit_len,
	input wire logic line_in,
	output logic line_out,
	output logic got,
	output logic [9:0] got_word
);
	int n;
	initial
	begin
		line_out = 1'b1;
		got = 1'b0;
		got_word = '0;
	end
	// Sends start, data, ninth and stop, then one idle bit period.
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 12; i++)
		begin
			line_out <= (i < 11) ? f[i] : 1'b1;
			repeat (bit_len) @(posedge clk);
		end
	endtask : send
	// Samples each bit in its middle and reports stop, ninth and data.
	always @(posedge clk)
	begin
		got <= 1'b0;
		if (line_in === 1'b0)
		begin
			repeat (bit_len / 2) @(posedge clk);
			for (n = 0; n < 10; n++)
			begin
				repeat (bit_len) @(posedge clk);
				got_word[n] <= line_in;
			end
			got <= 1'b1;
		end
	end
endmodule : serial_peer

// ===== bench/tb_serial_channel.sv
// Self-checking bench for the asynchronous serial channel.
`timescale 1ns/1ns
module tb_serial_channel
	import serial_channel_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [4:0] address = '0;
	logic [31:0] writedata = '0;
	logic [31:0] readdata;
	logic waitrequest, fv_out, fv_oe, sd_in, got, nb, sd_out, sd_oe;
	logic [9:0] got_word;
	logic [7:0] bit_len = 8'h10;
	logic [7:0] b, c;
	logic [2:0] ext;
	cfg_t cfg;
	int error_cnt = 0;
	int checked = 0;
	logic [31:0] rd_q[$];
	logic [9:0] tx_q[$];

	serial_channel u_dut (.ref_clk(ref_clk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.frame_valid_line_in(1'b1), .frame_valid_line_out(fv_out),
		.frame_valid_line_oe(fv_oe), .serial_data_line_in(sd_in),
		.serial_data_line_out(sd_out), .serial_data_line_oe(sd_oe),
		.channel_cfg(cfg));
	serial_peer u_peer (.clk(ref_clk), .bit_len(bit_len), .line_in(fv_out),
		.line_out(sd_in), .got(got), .got_word(got_word));

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic limit(int k, int n);
		if (k >= n)
		begin
			error_cnt++;
			finish_test();
		end
	endtask : limit
	// Read requests note the expected word; d is that word.
	task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
		int k;
		if (!w)
			rd_q.push_back(d);
		@(posedge ref_clk);
		address <= a;
		write <= w;
		read <= !w;
		writedata <= d;
		for (k = 0; k < 20; k++)
		begin
			@(posedge ref_clk);
			if (waitrequest === 1'b0)
				break;
		end
		limit(k, 20);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	function automatic logic ninth(logic [2:0] e, logic [7:0] d);
		case (e[1:0])
			2'b00: return 1'b1;
			2'b01: return ^d;
			2'b10: return ~^d;
			default: return e[2];
		endcase
	endfunction : ninth
	function automatic logic [31:0] st(logic ri, logic ti, logic n9,
		logic ov);
		return {24'h0, 1'b0, ov, 1'b0, n9, 1'b0, ti, 1'b0, ri};
	endfunction : st
	function automatic logic [31:0] cfgx(logic [4:0] m);
		logic p, l;
		p = m[4:3] == 2'b10;
		l = m[4:3] == 2'b11;
		return {24'h0, m[4:3] == 2'b01, p & ~m[0], p & m[0], p & m[0] & m[1],
			l, l & m[2], l & m[1], l & m[0]};
	endfunction : cfgx
	task automatic tx(logic [7:0] d);
		tx_q.push_back({1'b1, ninth(ext, d), d});
		bus(1'b1, DATA_OFS, {24'h0, d});
	endtask : tx
	task automatic drain();
		int k;
		for (k = 0; k < 3000 && tx_q.size() > 0; k++)
			@(posedge ref_clk);
		limit(k, 3000);
	endtask : drain

	always @(posedge ref_clk)
	begin
		if (read === 1'b1 && waitrequest === 1'b0)
			chk("readdata", rd_q.pop_front(), readdata);
		if (got === 1'b1)
		begin
			chk("frame", {22'h0, tx_q.pop_front()}, {22'h0, got_word});
			chk("tx_oe", 32'h1, {31'h0, fv_oe});
			chk("rx_pins", 32'h1, {30'h0, sd_oe, sd_out});
		end
	end
	initial
	begin
		forever #25 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		error_cnt++;
		finish_test();
	end
	initial
	begin
		b = $urandom(25);
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		bus(1'b0, DIV_OFS, 32'h1);
		bus(1'b0, STAT_OFS, st(0, 1, 0, 0));
		bus(1'b1, STAT_OFS, 32'h08);
		bus(1'b0, STAT_OFS, st(0, 0, 0, 0));
		bus(1'b1, STAT_OFS, 32'h0c);
		bus(1'b0, STAT_OFS, st(0, 1, 0, 0));
		bus(1'b1, 5'h14, 32'hff);
		bus(1'b0, 5'h14, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 32; i++)
		begin
			if (i[4:3] == 2'b10 && i[1:0] == 2'b10)
				continue;
			bus(1'b1, CTRL_OFS, i);
			bus(1'b0, CFG_OFS, cfgx(i[4:0]));
			chk("cfg", cfgx(i[4:0]), {24'h0, cfg});
		end
		$display("test decode done");
		for (int e = 0; e < 4; e++)
		begin
			ext = $urandom;
			ext[1:0] = e[1:0];
			bus(1'b1, CTRL_OFS, {27'h0, MODE_ASYNC, ext});
			b = $urandom;
			c = $urandom;
			nb = ninth(ext, c);
			fork
				tx(b);
				u_peer.send({1'b1, nb, c, 1'b0});
			join
			drain();
			bus(1'b0, STAT_OFS, st(1, 1, nb, 0));
			bus(1'b0, DATA_OFS, {24'h0, c});
			bus(1'b0, STAT_OFS, st(0, 1, nb, 0));
		end
		$display("test duplex done");
		ext = 3'b001;
		bus(1'b1, CTRL_OFS, {27'h0, MODE_ASYNC, ext});
		b = $urandom;
		u_peer.send({1'b1, ~^b, b, 1'b0});
		bus(1'b0, STAT_OFS, st(0, 1, ~^b, 0));
		bus(1'b0, DATA_OFS, {24'h0, c});
		for (int j = 0; j < 2; j++)
		begin
			b = $urandom;
			u_peer.send({1'b1, ^b, b, 1'b0});
		end
		bus(1'b0, STAT_OFS, st(1, 1, ^b, 1));
		bus(1'b0, DATA_OFS, {24'h0, b});
		bus(1'b1, STAT_OFS, 32'h80);
		bus(1'b0, STAT_OFS, st(0, 1, ^b, 0));
		bus(1'b1, STAT_OFS, 32'hc3);
		bus(1'b1, STAT_OFS, 32'h41);
		bus(1'b0, STAT_OFS, st(1, 1, ^b, 1));
		bus(1'b1, STAT_OFS, 32'h82);
		bus(1'b0, STAT_OFS, st(0, 1, ^b, 0));
		$display("test receive errors done");
		nb = ^b;
		b = $urandom;
		tx(b);
		c = $urandom;
		bus(1'b1, DATA_OFS, {24'h0, ~c});
		tx(c);
		bus(1'b0, STAT_OFS, st(0, 0, nb, 0));
		drain();
		bus(1'b0, STAT_OFS, st(0, 1, nb, 0));
		$display("test hold replace done");
		bus(1'b1, DIV_OFS, 32'h2);
		bus(1'b0, DIV_OFS, 32'h2);
		bit_len <= 8'h20;
		b = $urandom;
		c = $urandom;
		fork
			tx(b);
			u_peer.send({1'b1, ^c, c, 1'b0});
		join
		drain();
		bus(1'b0, DATA_OFS, {24'h0, c});
		$display("test divider done");
		finish_test();
	end
endmodule : tb_serial_channel
